/* rtl/operating_mode_controller.sv */
// Operating-mode sequencer with serial mode select and per-mode enables
`timescale 1ns/10ps
`default_nettype none
module operating_mode_controller
   import opmode_pkg::*;
(
   input  wire logic MCLK,
   input  wire logic RESET,
   input  wire logic SPI_CLK,
   input  wire logic SPI_CSN,
   input  wire logic SPI_DIN,
   input  wire logic LIN_BUS,
   input  wire logic LIN_WAKE,
   input  wire logic MON_IN,
   input  wire logic REG_CURRENT_LOW,
   output logic      RXD,
   output logic      DOUT,
   output logic      DOUT_OE,
   output logic      BUS_WAKE_FLAG,
   output logic [2:0] MODE,
   output enables_t  ENABLES
);
   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         sync1_q <= 6'h3;
         sync2_q <= 6'h3;
      end
      else
      begin
         sync1_q <= {REG_CURRENT_LOW, MON_IN, LIN_WAKE, SPI_DIN, LIN_BUS, SPI_CSN};
         sync2_q <= sync1_q;
      end
   end

   logic csn_s;
   logic bus_s;
   logic din_s;
   logic lwake_s;
   logic mon_s;
   logic ilow_s;
   logic sclk_s1_q;
   logic sclk_s2_q;
   assign {ilow_s, mon_s, lwake_s, din_s, bus_s, csn_s} = sync2_q;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
      end
      else
      begin
         sclk_s1_q <= SPI_CLK;
         sclk_s2_q <= sclk_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial receiver
   ctrl_word_t word;

   serial_word_rx u_rx
   (
      .clk    (MCLK),
      .rst    (RESET),
      .sclk_s (sclk_s2_q),
      .csn_s  (csn_s),
      .din_s  (din_s),
      .word   (word)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode state
   typedef struct packed {
      mode_t      mode;
      logic       wdog_en;
      logic       ls1;
      logic       ls2;
      logic       led;
      logic       meas;
      logic       mon;
      logic       supply;
      logic       mon_prev;
      logic       lwake_prev;
      logic       wake_latched;
      logic       bus_flag;
      logic [1:0] dout_cnt;
      enables_t   en;
      logic       rxd;
   } ctl_state_t;

   ctl_state_t st_q;
   ctl_state_t st_d;

   function automatic logic msel_legal(input logic [2:0] m);
      return m == MSEL_ACTIVE || m == MSEL_LIN_SLEEP || m == MSEL_RX_ONLY ||
             m == MSEL_STOP || m == MSEL_SLEEP;
   endfunction : msel_legal

   function automatic mode_t msel_to_mode(input logic [2:0] m);
      mode_t r;
      r = MODE_ACTIVE;
      unique case (m)
         MSEL_LIN_SLEEP: r = MODE_LIN_SLEEP;
         MSEL_RX_ONLY:   r = MODE_RX_ONLY;
         MSEL_STOP:      r = MODE_STOP;
         MSEL_SLEEP:     r = MODE_SLEEP;
         default:        r = MODE_ACTIVE;
      endcase
      return r;
   endfunction : msel_to_mode

   logic mon_edge;
   logic lin_wake_ev;
   logic mode_change;
   mode_t next_mode;

   always_comb
   begin
      st_d          = st_q;
      st_d.mon_prev = mon_s;
      st_d.lwake_prev = lwake_s;
      mon_edge      = st_q.en.monitor_on && (mon_s != st_q.mon_prev);
      lin_wake_ev   = lwake_s && (st_q.en.lin_wake_on || st_q.mode == MODE_LIN_SLEEP);
      next_mode     = st_q.mode;
      if (st_q.dout_cnt != 2'h0)
         st_d.dout_cnt = st_q.dout_cnt - 2'h1;
      // Serial command: only selectable modes, never standby
      if (word.valid && st_q.en.spi_on && msel_legal(word.msel))
      begin
         next_mode    = msel_to_mode(word.msel);
         st_d.wdog_en = word.wdog_en;
         st_d.ls1     = word.ls1;
         st_d.ls2     = word.ls2;
         st_d.led     = word.led;
         st_d.meas    = word.meas;
         if (next_mode == MODE_ACTIVE || next_mode == MODE_LIN_SLEEP ||
             next_mode == MODE_RX_ONLY)
         begin
            st_d.mon    = word.mon;
            st_d.supply = word.supply;
         end
      end
      else if (st_q.mode == MODE_SLEEP && (mon_edge || lin_wake_ev))
         next_mode = MODE_STANDBY;
      mode_change = next_mode != st_q.mode;
      if (mode_change)
      begin
         st_d.wake_latched = 1'b0;
         st_d.bus_flag     = 1'b0;
      end
      // Wake event latches receive line low until next mode change
      if (lin_wake_ev)
      begin
         st_d.wake_latched = 1'b1;
         if (st_q.mode == MODE_LIN_SLEEP)
            st_d.bus_flag = 1'b1;
         // Pulse once per wake onset, even if the detector level lingers
         if ((st_q.mode == MODE_STOP || st_q.mode == MODE_SLEEP) && !st_q.lwake_prev)
            st_d.dout_cnt = WAKE_PULSE_CYC;
      end
      if (mon_edge && st_q.mode == MODE_STOP)
         st_d.dout_cnt = WAKE_PULSE_CYC;
      st_d.mode = next_mode;
      // Enables derived from the new mode in one register load, except monitor_on, which follows the stored mon bit in every mode
      st_d.en = '0;
      st_d.en.regulator_on = next_mode != MODE_SLEEP;
      st_d.en.spi_on       = next_mode != MODE_SLEEP;
      st_d.en.monitor_on   = st_d.mon;
      st_d.en.supply_on    = st_d.supply && next_mode != MODE_SLEEP;
      unique case (next_mode)
         MODE_STANDBY:
         begin
            st_d.en.watchdog_on = 1'b1;
            st_d.en.lin_wake_on = 1'b1;
         end
         MODE_ACTIVE, MODE_LIN_SLEEP, MODE_RX_ONLY:
         begin
            st_d.en.watchdog_on          = 1'b1;
            st_d.en.low_side_switch_one  = st_d.ls1;
            st_d.en.low_side_switch_two  = st_d.ls2;
            st_d.en.high_side_led_driver = st_d.led;
            st_d.en.meas_on              = st_d.meas;
            st_d.en.adc_reference_output = 1'b1;
            st_d.en.vmon_on              = 1'b1;
            st_d.en.lin_tx_on     = next_mode == MODE_ACTIVE;
            st_d.en.lin_rx_on     = next_mode != MODE_LIN_SLEEP;
            st_d.en.lin_pullup_on = next_mode != MODE_LIN_SLEEP;
            st_d.en.lin_wake_on   = next_mode == MODE_LIN_SLEEP;
         end
         MODE_STOP:
         begin
            st_d.en.watchdog_on = st_d.wdog_en && !ilow_s;
            st_d.en.lin_wake_on = 1'b1;
         end
         MODE_SLEEP:
         begin
            st_d.en.watchdog_on = st_d.wdog_en;
            st_d.en.lin_wake_on = 1'b1;
         end
      endcase
      // Receive line: bus level when receiving, else active-low wake flag
      st_d.rxd = st_d.en.lin_rx_on ? bus_s : !st_d.wake_latched;
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         st_q                 <= '0;
         st_q.mode            <= MODE_STANDBY;
         st_q.en.regulator_on <= 1'b1;
         st_q.en.watchdog_on  <= 1'b1;
         st_q.en.lin_wake_on  <= 1'b1;
         st_q.en.spi_on       <= 1'b1;
         st_q.rxd             <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   assign RXD           = st_q.rxd;
   assign DOUT          = 1'b0;
   assign DOUT_OE       = st_q.dout_cnt != 2'h0;
   assign BUS_WAKE_FLAG = st_q.bus_flag;
   assign MODE          = st_q.mode;
   assign ENABLES       = st_q.en;
endmodule : operating_mode_controller
`default_nettype wire

/* rtl/opmode_pkg.sv */
// Constants and types for the operating-mode controller
`default_nettype none
package opmode_pkg;
   // Mode-select codes carried in bits 2:0 of the serial control word
   localparam logic [2:0] MSEL_ACTIVE    = 3'h1;
   localparam logic [2:0] MSEL_LIN_SLEEP = 3'h2;
   localparam logic [2:0] MSEL_RX_ONLY   = 3'h3;
   localparam logic [2:0] MSEL_STOP      = 3'h4;
   localparam logic [2:0] MSEL_SLEEP     = 3'h5;
   // Serial control word layout
   localparam int         WORD_BITS      = 16;
   localparam int         MSEL_LSB       = 0;
   localparam int         WDOG_EN_BIT    = 3;
   localparam int         LS1_BIT        = 4;
   localparam int         LS2_BIT        = 5;
   localparam int         LED_BIT        = 6;
   localparam int         MEAS_BIT       = 7;
   localparam int         MON_BIT        = 8;
   localparam int         SUPPLY_BIT     = 9;
   localparam logic [3:0] BITCNT_LAST    = 4'hF;
   // Wake-up pulse on the serial data output, in internal cycles
   localparam logic [1:0] WAKE_PULSE_CYC = 2'h2;

   typedef enum logic [2:0] {
      MODE_STANDBY,
      MODE_ACTIVE,
      MODE_LIN_SLEEP,
      MODE_RX_ONLY,
      MODE_STOP,
      MODE_SLEEP
   } mode_t;

   typedef struct packed {
      logic regulator_on;
      logic watchdog_on;
      logic monitor_on;
      logic supply_on;
      logic low_side_switch_one;
      logic low_side_switch_two;
      logic high_side_led_driver;
      logic meas_on;
      logic adc_reference_output;
      logic vmon_on;
      logic lin_tx_on;
      logic lin_rx_on;
      logic lin_pullup_on;
      logic lin_wake_on;
      logic spi_on;
   } enables_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] msel;
      logic       wdog_en;
      logic       ls1;
      logic       ls2;
      logic       led;
      logic       meas;
      logic       mon;
      logic       supply;
   } ctrl_word_t;
endpackage : opmode_pkg
`default_nettype wire

/* rtl/serial_word_rx.sv */
// Serial control-word receiver, LSB first, sampled on falling clock edge
`timescale 1ns/10ps
`default_nettype none
module serial_word_rx
   import opmode_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk_s,
   input  wire logic       csn_s,
   input  wire logic       din_s,
   output ctrl_word_t      word
);
   typedef struct packed {
      logic [WORD_BITS-1:0] shift;
      logic [3:0]           cnt;
      logic                 sclk_prev;
      ctrl_word_t           word;
   } rx_state_t;

   rx_state_t st_q;
   rx_state_t st_d;

   always_comb
   begin
      st_d            = st_q;
      st_d.word.valid = 1'b0;
      st_d.sclk_prev  = sclk_s;
      if (csn_s)
      begin
         st_d.cnt = '0;
      end
      else if (st_q.sclk_prev && !sclk_s)
      begin
         // LSB first: shift right, new bit enters at the top
         st_d.shift = {din_s, st_q.shift[WORD_BITS-1:1]};
         st_d.cnt   = st_q.cnt + 4'h1;
         if (st_q.cnt == BITCNT_LAST)
         begin
            st_d.word.valid   = 1'b1;
            st_d.word.msel    = st_d.shift[MSEL_LSB+:3];
            st_d.word.wdog_en = st_d.shift[WDOG_EN_BIT];
            st_d.word.ls1     = st_d.shift[LS1_BIT];
            st_d.word.ls2     = st_d.shift[LS2_BIT];
            st_d.word.led     = st_d.shift[LED_BIT];
            st_d.word.meas    = st_d.shift[MEAS_BIT];
            st_d.word.mon     = st_d.shift[MON_BIT];
            st_d.word.supply  = st_d.shift[SUPPLY_BIT];
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign word = st_q.word;
endmodule : serial_word_rx
`default_nettype wire

/* dv/opmode_checker.sv */
// Port assertions for the operating-mode controller
`timescale 1ns/10ps
`default_nettype none
module opmode_checker
   import opmode_pkg::*;
(
   input wire logic       MCLK,
   input wire logic       RESET,
   input wire logic       RXD,
   input wire logic       DOUT_OE,
   input wire logic       BUS_WAKE_FLAG,
   input wire logic [2:0] MODE,
   input wire enables_t   ENABLES
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   a_reg_sleep: assert property (ENABLES.regulator_on == (MODE != MODE_SLEEP))
      else $error("regulator wrong for mode");
   a_sw_forced_off: assert property (MODE inside {MODE_STANDBY, MODE_STOP, MODE_SLEEP}
      |-> !(ENABLES.low_side_switch_one | ENABLES.low_side_switch_two
      | ENABLES.high_side_led_driver | ENABLES.meas_on)) else $error("switch on");
   a_wake_enable: assert property (MODE != MODE_RX_ONLY
      |-> ENABLES.lin_wake_on == (MODE != MODE_ACTIVE)) else $error("bus wake enable wrong");
   a_tx_active: assert property (ENABLES.lin_tx_on |-> MODE == MODE_ACTIVE)
      else $error("transmit on outside active");
   a_rx_only: assert property (MODE == MODE_RX_ONLY
      |-> ENABLES.lin_rx_on && !ENABLES.lin_tx_on) else $error("receive-only stages wrong");
   a_lsleep_off: assert property (MODE == MODE_LIN_SLEEP
      |-> !(ENABLES.lin_tx_on | ENABLES.lin_rx_on | ENABLES.lin_pullup_on))
      else $error("transceiver on in lin sleep");
   a_oe_two_cyc: assert property ($rose(DOUT_OE) |=> DOUT_OE ##1 !DOUT_OE)
      else $error("wake pulse length wrong");
   a_standby_auto: assert property ($changed(MODE) && MODE == MODE_STANDBY
      |-> $past(MODE) == MODE_SLEEP) else $error("standby entered by command");
   a_rxd_hold: assert property (MODE == MODE_STOP && !RXD
      |=> !RXD || MODE != MODE_STOP) else $error("wake flag released early");
   a_flag_cause: assert property ($rose(BUS_WAKE_FLAG) |-> $past(MODE) == MODE_LIN_SLEEP)
      else $error("bus wake flag outside lin sleep");
endmodule : opmode_checker
bind operating_mode_controller opmode_checker u_chk (.MCLK(MCLK), .RESET(RESET),
   .RXD(RXD), .DOUT_OE(DOUT_OE), .BUS_WAKE_FLAG(BUS_WAKE_FLAG), .MODE(MODE),
   .ENABLES(ENABLES));
`default_nettype wire

/* dv/spi_host_model.sv */
// Host model that shifts control words into the controller
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
   input  wire logic clk,
   output logic      sclk,
   output logic      csn,
   output logic      din
);
   initial
   begin
      sclk = 1'b0;
      csn  = 1'b1;
      din  = 1'b0;
   end
   // Link period of eight clocks; idle levels follow the pin pulls
   task automatic send(input logic [15:0] w);
      @(posedge clk) csn <= 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         repeat (4) @(posedge clk);
         din  <= w[i];
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      csn <= 1'b1;
      din <= 1'b0;
   endtask : send
endmodule : spi_host_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the operating-mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
   $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module testbench
   import opmode_pkg::*;
;
   logic        MCLK = 1'b0, RESET = 1'b1, LIN_BUS = 1'b1, LIN_WAKE = 1'b0;
   logic        MON_IN = 1'b0, REG_CURRENT_LOW = 1'b0;
   logic        sclk, csn, din, RXD, DOUT, DOUT_OE, BUS_WAKE_FLAG;
   logic [2:0]  MODE;
   enables_t    ENABLES;
   int          err_total = 0, compares = 0;
   logic        mon_q = 1'b0, sup_q = 1'b0;
   logic [15:0] w = 16'h0;
   localparam logic [14:0] MASK = 15'h7FF9;
   always #4 MCLK = ~MCLK;
   spi_host_model u_host (.clk(MCLK), .sclk(sclk), .csn(csn), .din(din));
   operating_mode_controller DUT (.MCLK(MCLK), .RESET(RESET), .SPI_CLK(sclk),
      .SPI_CSN(csn), .SPI_DIN(din), .LIN_BUS(LIN_BUS), .LIN_WAKE(LIN_WAKE),
      .MON_IN(MON_IN), .REG_CURRENT_LOW(REG_CURRENT_LOW), .RXD(RXD), .DOUT(DOUT),
      .DOUT_OE(DOUT_OE), .BUS_WAKE_FLAG(BUS_WAKE_FLAG), .MODE(MODE), .ENABLES(ENABLES));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic enables_t exp_en(logic [2:0] m);
      enables_t e;
      e = '0;
      e.regulator_on = (m != MODE_SLEEP);
      e.spi_on       = (m != MODE_SLEEP);
      e.monitor_on   = mon_q;
      e.supply_on    = sup_q && (m != MODE_SLEEP);
      e.watchdog_on  = (m == MODE_SLEEP) ? w[3] : 1'b1;
      if (m == MODE_STOP)
         e.watchdog_on = w[3] && !REG_CURRENT_LOW;
      if (m == MODE_ACTIVE)
      begin
         {e.meas_on, e.high_side_led_driver, e.low_side_switch_two, e.low_side_switch_one} = w[7:4];
         {e.adc_reference_output, e.vmon_on, e.lin_tx_on, e.lin_rx_on} = 4'hF;
      end
      return e;
   endfunction : exp_en
   task automatic wt(int n);
      repeat (n) @(posedge MCLK);
      @(negedge MCLK);
   endtask : wt
   task automatic cmd(logic [2:0] c, logic [6:0] hi);
      w = {6'h0, hi, c};
      if (c inside {MSEL_ACTIVE, MSEL_LIN_SLEEP, MSEL_RX_ONLY})
         {sup_q, mon_q} = w[9:8];
      u_host.send(w);
      wt(8);
   endtask : cmd
   task automatic chk(logic [2:0] m);
      `CHK(MODE, m)
      `CHK(ENABLES & MASK, exp_en(m) & MASK)
   endtask : chk
   task automatic pulse_wake();
      @(posedge MCLK) LIN_WAKE <= 1'b1;
      @(posedge MCLK) LIN_WAKE <= 1'b0;
      wt(6);
   endtask : pulse_wake
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #300000;
      err_total++;
      close_out();
   end
   initial
   begin
      void'($urandom(32'h973c_90a5));
      repeat (4) @(posedge MCLK);
      RESET <= 1'b0;
      wt(1);
      chk(MODE_STANDBY);
      `CHK(RXD, 1'b1)
      for (int i = 0; i < 3; i++)
      begin
         cmd(i == 0 ? 3'h0 : 3'(5 + i), 7'($urandom));
         chk(MODE_STANDBY);
      end
      @(posedge MCLK) REG_CURRENT_LOW <= 1'($urandom);
      cmd(MSEL_STOP, {6'($urandom), 1'b1});
      chk(MODE_STOP);
      @(posedge MCLK) REG_CURRENT_LOW <= ~REG_CURRENT_LOW;
      wt(6);
      chk(MODE_STOP);
      @(posedge MCLK) LIN_WAKE <= 1'b1;
      for (int k = 0; k < 10 && DOUT_OE !== 1'b1; k++)
         @(negedge MCLK);
      `CHK(DOUT_OE, 1'b1)
      `CHK(DOUT, 1'b0)
      @(posedge MCLK) LIN_WAKE <= 1'b0;
      @(negedge MCLK);
      `CHK(DOUT_OE, 1'b1)
      @(negedge MCLK);
      `CHK(DOUT_OE, 1'b0)
      wt(6);
      `CHK(RXD, 1'b0)
      `CHK(MODE, MODE_STOP)
      for (int i = 0; i < 12; i++)
      begin
         cmd($urandom_range(1) ? MSEL_ACTIVE : MSEL_STOP, 7'($urandom));
         chk(w[2:0] == MSEL_ACTIVE ? MODE_ACTIVE : MODE_STOP);
         @(posedge MCLK) LIN_BUS <= 1'($urandom);
         wt(6);
         if (MODE === MODE_ACTIVE)
            `CHK(RXD, LIN_BUS)
      end
      cmd(MSEL_LIN_SLEEP, 7'($urandom));
      `CHK(MODE, MODE_LIN_SLEEP)
      pulse_wake();
      `CHK(BUS_WAKE_FLAG, 1'b1)
      `CHK(RXD, 1'b0)
      `CHK({MODE, ENABLES.lin_rx_on}, {MODE_LIN_SLEEP, 1'b0})
      cmd(MSEL_ACTIVE, 7'($urandom));
      `CHK(BUS_WAKE_FLAG, 1'b0)
      chk(MODE_ACTIVE);
      cmd(MSEL_RX_ONLY, 7'($urandom));
      for (int i = 0; i < 2; i++)
      begin
         @(posedge MCLK) LIN_BUS <= 1'(i);
         wt(6);
         `CHK(RXD, 1'(i))
      end
      cmd(MSEL_ACTIVE, 7'($urandom) | 7'h20);
      cmd(MSEL_SLEEP, 7'($urandom));
      chk(MODE_SLEEP);
      cmd(MSEL_STOP, 7'($urandom));
      `CHK(MODE, MODE_SLEEP)
      @(posedge MCLK) MON_IN <= ~MON_IN;
      wt(8);
      chk(MODE_STANDBY);
      close_out();
   end
endmodule : testbench
`default_nettype wire
